// ==== hw/aur_baud_tick.sv ====
// Baud tick divider producing one-cycle enables at sixteen times baud.
`timescale 1ns/1ps
module aur_baud_tick
	import aur_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  tick
);

	logic [DIV_W-1:0] count_r;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count_r <= '0;
			tick    <= 1'b0;
		end else if (!run) begin
			count_r <= '0;
			tick    <= 1'b0;
		end else if (count_r >= divisor) begin
			count_r <= '0;
			tick    <= 1'b1;
		end else begin
			count_r <= count_r + 1'b1;
			tick    <= 1'b0;
		end
	end

endmodule

// ==== hw/aur_pkg.sv ====
// Package with register map, field positions and types of the receiver.
package aur_pkg;

	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 8;

	// Register indices; byte address equals the index on this plain port.
	localparam logic [3:0]  ADDR_RX_STAT    = 4'h0;
	localparam logic [3:0]  ADDR_RX_DATA    = 4'h1;
	localparam logic [3:0]  ADDR_CORE_IRQ   = 4'h2;
	localparam logic [3:0]  ADDR_PIRQ_EN    = 4'h3;
	localparam logic [3:0]  ADDR_PIRQ_FLG   = 4'h4;
	localparam logic [3:0]  ADDR_TX_STAT    = 4'h5;
	localparam logic [3:0]  ADDR_BAUD_CTL   = 4'h6;
	localparam logic [3:0]  ADDR_BAUD_LO    = 4'h7;
	localparam logic [3:0]  ADDR_BAUD_HI    = 4'h8;

	// receive_status_control fields.
	localparam int          RS_SERIAL_PORT_ENABLE         = 7;
	localparam int          RS_RX9          = 6;
	localparam int          RS_SREN         = 5;
	localparam int          RS_CONTINUOUS_RECEIVE_ENABLE         = 4;
	localparam int          RS_ADDRESS_DETECT_ENABLE        = 3;
	localparam int          RS_FRAMING_ERROR_STATUS         = 2;
	localparam int          RS_OVERRUN_FLAG         = 1;
	localparam int          RS_NINTH_RECEIVED_BIT         = 0;
	localparam logic [7:0]  RS_WR_MASK      = 8'hF8;

	// transmit_status_control, core and peripheral interrupt, and baud control fields.
	localparam int          TS_SYNC         = 4;
	localparam int          CI_GIE          = 7;
	localparam int          CI_PERIPHERAL_INTERRUPT_ENABLE         = 6;
	localparam int          PI_RECEIVE_INTERRUPT_ENABLE         = 5;
	localparam int          PI_RECEIVE_READY_FLAG         = 5;
	localparam int          BC_IDLE         = 6;

	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [7:0]  TX_STAT_RESET   = 8'h02;

	// Baud divider: tick period is (divisor + 1) system clocks.
	localparam int          DIV_W           = 16;
	localparam int          OVERSAMPLE      = 16;
	localparam logic [3:0]  HALF_BIT        = 4'h7;
	localparam logic [3:0]  FULL_BIT        = 4'hF;
	localparam logic [3:0]  VOTE_A          = 4'h7;
	localparam logic [3:0]  VOTE_B          = 4'h8;
	localparam logic [3:0]  VOTE_C          = 4'h9;
	localparam logic [3:0]  LAST_DATA_8     = 4'h7;
	localparam logic [3:0]  LAST_DATA_9     = 4'h8;
	localparam int          FIFO_DEPTH      = 2;

	typedef enum logic [1:0] {
		AUR_IDLE  = 2'b00,
		AUR_START = 2'b01,
		AUR_DATA  = 2'b11,
		AUR_STOP  = 2'b10
	} aur_state_e;

	// One stored character: framing error and nine data bits.
	typedef struct packed {
		logic       framing_error_status;
		logic [8:0] data;
	} aur_char_s;

	// Software access strobes.
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} aur_bus_s;

endpackage

// ==== hw/aur_receiver.sv ====
// Asynchronous serial receiver with two-deep character FIFO.
// Operation
// - Oversample at sixteen ticks per bit
// - Completed characters enter two-deep FIFO
// - Falling edge starts; confirm low mid-start
// - High mid-start aborts silently, resume search
// - Bit centres each bit time, majority vote
// - Low stop sample marks framing error
// - After stop, push character, raise ready
// - Data read pops oldest character
// - Ready flag equals enabled and not empty
// - Interrupt needs all three enables set
// - Framing status follows oldest entry
// - Port disable clears framing; no interrupt
// - Third character when full sets overrun
// - Overrun cleared by receive or port disable
// - Nine-bit mode; ninth bit of oldest
// - Nine-bit address mode keeps only ninth-bit-set characters
// - LSB first, low start, high stop
// - Port disable holds receiver in reset
`timescale 1ns/1ps
module aur_receiver
	import aur_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic [DATA_W-1:0] bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic      [DATA_W-1:0] bus_rdata,
	input  wire logic              receive_data_pin,
	output logic                   receive_ready_flag,
	output logic                   irq
);

	aur_bus_s          bus;
	logic [7:0]        rx_stat_ctl_r;
	logic [7:0]        core_irq_r;
	logic [7:0]        pirq_en_r;
	logic [7:0]        tx_stat_r;
	logic [7:0]        baud_ctl_r;
	logic [7:0]        baud_lo_r;
	logic [7:0]        baud_hi_r;
	logic              pin_meta_r;
	logic              pin_sync_r;
	logic              pin_prev_r;
	logic              tick;
	logic              port_on;
	logic              rx_on;
	aur_state_e        state_r;
	logic [3:0]        phase_r;
	logic [3:0]        bit_idx_r;
	logic [8:0]        shift_r;
	logic [2:0]        votes_r;
	logic              bit_val;
	logic              stop_done;
	logic              keep_char;
	aur_char_s         fifo_r [FIFO_DEPTH];
	aur_char_s         new_char;
	aur_char_s         head;
	logic              rd_ptr_r;
	logic              wr_ptr_r;
	logic [1:0]        fill_r;
	logic              pop;
	logic              push;
	logic              overrun_r;
	logic [7:0]        stat_view;
	logic [7:0]        pirq_view;
	logic [7:0]        rdata_nxt;
	logic [1:0]        fill_nxt;
	logic              pin_fall;
	logic              last_bit;
	logic              ready_nxt;
	logic              irq_enabled;

	assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

	assign port_on = rx_stat_ctl_r[RS_SERIAL_PORT_ENABLE];
	assign rx_on   = port_on & rx_stat_ctl_r[RS_CONTINUOUS_RECEIVE_ENABLE]
		& ~tx_stat_r[TS_SYNC];

	// Writable control registers.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rx_stat_ctl_r <= RESET_BYTE;
			core_irq_r    <= RESET_BYTE;
			pirq_en_r     <= RESET_BYTE;
			tx_stat_r     <= TX_STAT_RESET;
			baud_ctl_r    <= RESET_BYTE;
			baud_lo_r     <= RESET_BYTE;
			baud_hi_r     <= RESET_BYTE;
		end else if (bus.wr) begin
			unique case (bus.addr)
				ADDR_RX_STAT:  rx_stat_ctl_r <= bus.wdata & RS_WR_MASK;
				ADDR_CORE_IRQ: core_irq_r    <= bus.wdata;
				ADDR_PIRQ_EN:  pirq_en_r     <= bus.wdata;
				ADDR_TX_STAT:  tx_stat_r     <= bus.wdata | TX_STAT_RESET;
				ADDR_BAUD_CTL: baud_ctl_r    <= bus.wdata;
				ADDR_BAUD_LO:  baud_lo_r     <= bus.wdata;
				ADDR_BAUD_HI:  baud_hi_r     <= bus.wdata;
				default: ;
			endcase
		end
	end

	aur_baud_tick u_tick (
		.sys_clk (sys_clk),
		.reset   (reset),
		.run     (port_on),
		.divisor ({baud_hi_r, baud_lo_r}),
		.tick    (tick)
	);

	// The first flop feeds only the second.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin_meta_r <= 1'b1;
			pin_sync_r <= 1'b1;
			pin_prev_r <= 1'b1;
		end else begin
			pin_meta_r <= receive_data_pin;
			pin_sync_r <= pin_meta_r;
			if (tick) begin
				pin_prev_r <= pin_sync_r;
			end
		end
	end

	// A falling edge between two ticks; both samples idle high after reset,
	// so no false start follows reset or a re-enable.
	assign pin_fall = pin_prev_r && !pin_sync_r;

	// Majority of three samples around the centre of each bit.
	assign bit_val = (votes_r[0] & votes_r[1]) | (votes_r[0] & votes_r[2])
		| (votes_r[1] & votes_r[2]);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			votes_r <= 3'h7;
		end else if (tick) begin
			if (phase_r == VOTE_A - 4'h1 || phase_r == VOTE_B - 4'h1
				|| phase_r == VOTE_C - 4'h1) begin
				votes_r <= {votes_r[1:0], pin_sync_r};
			end
		end
	end

	assign stop_done = tick && state_r == AUR_STOP && phase_r == VOTE_C;
	assign keep_char = !(rx_stat_ctl_r[RS_ADDRESS_DETECT_ENABLE] && rx_stat_ctl_r[RS_RX9]
		&& !shift_r[8]);
	assign new_char  = '{framing_error_status: ~bit_val, data: shift_r};
	assign last_bit  = bit_idx_r == (rx_stat_ctl_r[RS_RX9]
		? LAST_DATA_9 : LAST_DATA_8);

	// Data recovery state machine on the sixteen-times tick.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r   <= AUR_IDLE;
			phase_r   <= '0;
			bit_idx_r <= '0;
			shift_r   <= '0;
		end else if (!port_on || !rx_on) begin
			state_r   <= AUR_IDLE;
			phase_r   <= '0;
			bit_idx_r <= '0;
		end else if (tick) begin
			unique case (state_r)
				AUR_IDLE: begin
					phase_r <= '0;
					if (pin_fall) begin
						state_r <= AUR_START;
					end
				end
				AUR_START: begin
					phase_r <= phase_r + 4'h1;
					// A high level at the start centre drops the frame.
					if (phase_r == HALF_BIT && pin_sync_r) begin
						phase_r <= '0;
						state_r <= AUR_IDLE;
					end
					// The start bit runs a whole bit time, so the data
					// phases below begin on a bit boundary and the votes
					// fall on the centre of each data bit.
					if (phase_r == FULL_BIT) begin
						phase_r   <= '0;
						state_r   <= AUR_DATA;
						bit_idx_r <= '0;
					end
				end
				AUR_DATA: begin
					phase_r <= phase_r + 4'h1;
					if (phase_r == VOTE_C) begin
						// LSB first: shift in from the top.
						if (rx_stat_ctl_r[RS_RX9]) begin
							shift_r <= {bit_val, shift_r[8:1]};
						end else begin
							shift_r <= {1'b0, bit_val, shift_r[7:1]};
						end
					end
					if (phase_r == FULL_BIT) begin
						phase_r   <= '0;
						bit_idx_r <= bit_idx_r + 4'h1;
						if (last_bit) begin
							state_r <= AUR_STOP;
						end
					end
				end
				AUR_STOP: begin
					phase_r <= phase_r + 4'h1;
					if (phase_r == VOTE_C) begin
						state_r <= AUR_IDLE;
					end
				end
			endcase
		end
	end

	// FIFO bookkeeping; a read of the data register pops the head.
	assign pop  = bus.rd && bus.addr == ADDR_RX_DATA && fill_r != 2'd0;
	assign push = stop_done && keep_char && !overrun_r
		&& (fill_r != 2'd2 || pop);
	assign head = fifo_r[rd_ptr_r];

	// Occupancy after this cycle's push and pop; ready and irq use it so
	// that they move on the same edge as the FIFO itself.
	assign fill_nxt    = fill_r + {1'b0, push} - {1'b0, pop};
	assign ready_nxt   = rx_on && fill_nxt != 2'd0;
	assign irq_enabled = pirq_en_r[PI_RECEIVE_INTERRUPT_ENABLE] && core_irq_r[CI_PERIPHERAL_INTERRUPT_ENABLE]
		&& core_irq_r[CI_GIE];

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			fifo_r[0] <= '0;
			fifo_r[1] <= '0;
			rd_ptr_r  <= 1'b0;
			wr_ptr_r  <= 1'b0;
			fill_r    <= 2'd0;
		end else if (!port_on) begin
			fifo_r[0] <= '0;
			fifo_r[1] <= '0;
			rd_ptr_r  <= 1'b0;
			wr_ptr_r  <= 1'b0;
			fill_r    <= 2'd0;
		end else begin
			if (push) begin
				fifo_r[wr_ptr_r] <= new_char;
				wr_ptr_r         <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			fill_r <= fill_nxt;
		end
	end

	// Overrun: a whole character ends while two are waiting.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			overrun_r <= 1'b0;
		end else if (!port_on || !rx_stat_ctl_r[RS_CONTINUOUS_RECEIVE_ENABLE]) begin
			overrun_r <= 1'b0;
		end else if (stop_done && keep_char && fill_r == 2'd2 && !pop) begin
			overrun_r <= 1'b1;
		end
	end

	assign stat_view = {rx_stat_ctl_r[7:3], head.framing_error_status & (fill_r != 2'd0),
		overrun_r, head.data[8]};
	assign pirq_view = {2'b00, receive_ready_flag, 5'b00000};

	always_comb begin
		rdata_nxt = RESET_BYTE;
		unique case (bus.addr)
			ADDR_RX_STAT:  rdata_nxt = stat_view;
			ADDR_RX_DATA:  rdata_nxt = head.data[7:0];
			ADDR_CORE_IRQ: rdata_nxt = core_irq_r;
			ADDR_PIRQ_EN:  rdata_nxt = pirq_en_r;
			ADDR_PIRQ_FLG: rdata_nxt = pirq_view;
			ADDR_TX_STAT:  rdata_nxt = tx_stat_r;
			ADDR_BAUD_CTL: rdata_nxt = {baud_ctl_r[7],
				state_r == AUR_IDLE, baud_ctl_r[5:0]};
			ADDR_BAUD_LO:  rdata_nxt = baud_lo_r;
			ADDR_BAUD_HI:  rdata_nxt = baud_hi_r;
			default:       rdata_nxt = RESET_BYTE;
		endcase
	end

	// Read data and status outputs, registered.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bus_rdata          <= RESET_BYTE;
			receive_ready_flag <= 1'b0;
			irq                <= 1'b0;
		end else begin
			if (bus.rd) begin
				bus_rdata <= rdata_nxt;
			end
			receive_ready_flag <= ready_nxt;
			irq                <= ready_nxt && irq_enabled;
		end
	end

endmodule

// ==== test/aur_line_tx.sv ====
// Remote serial transmitter model driving the receive line.
`timescale 1ns/1ps
module aur_line_tx (
	input  wire logic sys_clk,
	output logic      line
);
	initial line = 1'b1;

	// Sends one frame, LSB first, 16 clocks a bit, then idles.
	task automatic send(input logic [8:0] d, input int nbits,
		input logic stop);
		line <= 1'b0;
		repeat (16) @(posedge sys_clk);
		for (int i = 0; i < nbits; i++) begin
			line <= d[i];
			repeat (16) @(posedge sys_clk);
		end
		line <= stop;
		repeat (16) @(posedge sys_clk);
		line <= 1'b1;
		repeat (32) @(posedge sys_clk);
		#1;
	endtask

	// A low pulse far shorter than half a bit.
	task automatic glitch();
		line <= 1'b0;
		repeat (4) @(posedge sys_clk);
		line <= 1'b1;
		repeat (40) @(posedge sys_clk);
		#1;
	endtask
endmodule

// ==== test/aur_receiver_props.sv ====
// Concurrent checks on the serial receiver's ports.
`timescale 1ns/1ps
module aur_receiver_props
	import aur_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [DATA_W-1:0] bus_wdata,
	input wire logic              bus_wr,
	input wire logic              bus_rd,
	input wire logic [DATA_W-1:0] bus_rdata,
	input wire logic              receive_data_pin,
	input wire logic              receive_ready_flag,
	input wire logic              irq
);
	logic [7:0] line_age_r;
	wire logic  pop = bus_rd && bus_addr == ADDR_RX_DATA;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// Counts cycles since the line was last low, held at the top.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			line_age_r <= 8'h00;
		else if (!receive_data_pin)
			line_age_r <= 8'h00;
		else if (line_age_r != 8'hFF)
			line_age_r <= line_age_r + 8'h01;
	end

	sequence s_port_off;
		bus_wr && bus_addr == ADDR_RX_STAT && !bus_wdata[RS_SERIAL_PORT_ENABLE];
	endsequence
	sequence s_recv_off;
		bus_wr && bus_addr == ADDR_RX_STAT && !bus_wdata[RS_CONTINUOUS_RECEIVE_ENABLE];
	endsequence

	a_irq_needs_ready: assert property (
		!receive_ready_flag |-> !irq)
		else $error("irq high without ready flag");
	a_rdata_holds: assert property (
		!bus_rd |=> $stable(bus_rdata))
		else $error("read data changed without a read");
	a_port_off_clears: assert property (
		s_port_off |-> ##2 (!receive_ready_flag && !irq))
		else $error("port disable left ready or irq set");
	a_recv_off_ready: assert property (
		s_recv_off |-> ##2 !receive_ready_flag)
		else $error("ready flag set while receive disabled");
	a_ready_after_frame: assert property (
		$rose(receive_ready_flag) && !$past(bus_wr) && !$past(bus_wr, 2)
		&& !$past(bus_wr, 3) |-> line_age_r < 8'hC8)
		else $error("ready rose with no frame on the line");
	a_ready_fall_cause: assert property (
		$fell(receive_ready_flag) |-> $past(pop) || $past(bus_wr)
		|| $past(bus_wr, 2))
		else $error("ready fell without read or write");
	a_ready_holds: assert property (
		receive_ready_flag && !bus_rd && !bus_wr && !$past(bus_wr)
		&& !$past(bus_wr, 2) |=> receive_ready_flag)
		else $error("ready dropped with characters unread");
	a_irq_rise_cause: assert property (
		$rose(irq) |-> $rose(receive_ready_flag) || $past(bus_wr)
		|| $past(bus_wr, 2))
		else $error("irq rose without ready or enable write");
endmodule

bind aur_receiver aur_receiver_props i_props (
	.sys_clk           (sys_clk),
	.reset             (reset),
	.bus_addr          (bus_addr),
	.bus_wdata         (bus_wdata),
	.bus_wr            (bus_wr),
	.bus_rd            (bus_rd),
	.bus_rdata         (bus_rdata),
	.receive_data_pin  (receive_data_pin),
	.receive_ready_flag(receive_ready_flag),
	.irq               (irq)
);

// ==== test/testbench.sv ====
// Self-checking bench for the serial receiver.
`timescale 1ns/1ps
module testbench;
	import aur_pkg::*;
	localparam int LIMIT = 20000;
	logic              sys_clk = 1'b0;
	logic              reset = 1'b1;
	logic [ADDR_W-1:0] bus_addr = '0;
	logic [DATA_W-1:0] bus_wdata = '0;
	logic              bus_wr = 1'b0;
	logic              bus_rd = 1'b0;
	logic [DATA_W-1:0] bus_rdata;
	wire logic         pin;
	logic              ready;
	logic              irq;
	wire logic [7:0]   flags = {6'h00, ready, irq};
	int                miscompares = 0;
	int                n_tests = 0;
	int                cycles = 0;

	always #5 sys_clk = ~sys_clk;

	aur_receiver i_dut (
		.sys_clk           (sys_clk),
		.reset             (reset),
		.bus_addr          (bus_addr),
		.bus_wdata         (bus_wdata),
		.bus_wr            (bus_wr),
		.bus_rd            (bus_rd),
		.bus_rdata         (bus_rdata),
		.receive_data_pin  (pin),
		.receive_ready_flag(ready),
		.irq               (irq)
	);
	aur_line_tx i_tx (.sys_clk(sys_clk), .line(pin));

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		chk(bus_rdata, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		rd(ADDR_TX_STAT, TX_STAT_RESET);
		rd(ADDR_RX_STAT, RESET_BYTE);
		rd(4'hF, 8'h00);
		wr(ADDR_BAUD_LO, 8'h00);
		wr(ADDR_BAUD_HI, 8'h00);
		wr(ADDR_TX_STAT, 8'h00);
		wr(ADDR_CORE_IRQ, 8'hC0);
		wr(ADDR_PIRQ_EN, 8'h20);
		wr(ADDR_RX_STAT, 8'h90);
		rd(ADDR_RX_STAT, 8'h90);
		$display("test registers done");
		i_tx.send(9'h0A5, 8, 1'b1);
		i_tx.send(9'h03C, 8, 1'b0);
		chk(flags, 8'h03);
		wr(ADDR_PIRQ_FLG, 8'h00);
		rd(ADDR_PIRQ_FLG, 8'h20);
		wr(ADDR_CORE_IRQ, 8'h80);
		settle();
		chk(flags, 8'h02);
		wr(ADDR_CORE_IRQ, 8'hC0);
		rd(ADDR_RX_STAT, 8'h90);
		rd(ADDR_RX_DATA, 8'hA5);
		rd(ADDR_RX_STAT, 8'h94);
		rd(ADDR_RX_DATA, 8'h3C);
		chk(flags, 8'h00);
		$display("test two characters done");
		for (int i = 0; i < 3; i++)
			i_tx.send(9'(i * 16 + 1), 8, 1'b1);
		rd(ADDR_RX_STAT, 8'h92);
		rd(ADDR_RX_DATA, 8'h01);
		rd(ADDR_RX_DATA, 8'h11);
		chk(flags, 8'h00);
		i_tx.send(9'h077, 8, 1'b1);
		chk(flags, 8'h00);
		wr(ADDR_RX_STAT, 8'h80);
		rd(ADDR_RX_STAT, 8'h80);
		wr(ADDR_RX_STAT, 8'h90);
		i_tx.send(9'h055, 8, 1'b1);
		rd(ADDR_RX_DATA, 8'h55);
		$display("test overrun done");
		i_tx.send(9'h0F0, 8, 1'b0);
		wr(ADDR_RX_STAT, 8'h80);
		rd(ADDR_RX_STAT, 8'h84);
		i_tx.send(9'h0AA, 8, 1'b1);
		chk(flags, 8'h00);
		wr(ADDR_RX_STAT, 8'h90);
		rd(ADDR_RX_STAT, 8'h94);
		wr(ADDR_RX_STAT, 8'h00);
		rd(ADDR_RX_STAT, 8'h00);
		wr(ADDR_RX_STAT, 8'h90);
		settle();
		chk(flags, 8'h00);
		i_tx.glitch();
		chk(flags, 8'h00);
		i_tx.send(9'h0C3, 8, 1'b1);
		rd(ADDR_RX_DATA, 8'hC3);
		$display("test framing and start done");
		wr(ADDR_RX_STAT, 8'hD8);
		i_tx.send(9'h012, 9, 1'b1);
		chk(flags, 8'h00);
		i_tx.send(9'h1A7, 9, 1'b1);
		rd(ADDR_RX_STAT, 8'hD9);
		rd(ADDR_RX_DATA, 8'hA7);
		wr(ADDR_RX_STAT, 8'hD0);
		i_tx.send(9'h034, 9, 1'b1);
		rd(ADDR_RX_STAT, 8'hD0);
		rd(ADDR_RX_DATA, 8'h34);
		$display("test nine bit done");
		wr(ADDR_TX_STAT, 8'h10);
		i_tx.send(9'h066, 9, 1'b1);
		chk(flags, 8'h00);
		rd(ADDR_TX_STAT, 8'h12);
		wr(ADDR_TX_STAT, 8'h00);
		i_tx.send(9'h099, 9, 1'b1);
		rd(ADDR_RX_DATA, 8'h99);
		$display("test mode select done");
		give_verdict();
	end
endmodule
